/* File: design/lsp_pkg.sv */
// Constants for the LED sink output stagger and protection block.
// Assumes a single 250 MHz clock and an APB master for the control registers.
//
// Summary of operation
// - Supply-low lockout forces every sink output off, whatever latches or gate say.
// - Power-up and end of lockout clear all shift stages and latches to zero.
// - After power-up or lockout recovery the block is in normal mode.
// - Each successive sink output changes 20 ns after the preceding one.
// - Stagger on gate going active, latch-load rising, or clock rising with load held.
// - Delays accumulate: output k trails the first by k times 20 ns, 300 ns last.
// - Overtemperature shutdown holds all outputs off; they follow latches again afterwards.
// - In normal mode shift stages and latches keep working through overtemperature.
// - In open-LED test mode overtemperature also loads zero into every shift stage.
// - Gate high disables all outputs; gate low lets outputs follow latches.
// - Latch-load high makes latches copy shift stages; low makes them hold.
// - In test mode a faulted enabled output puts zero into its shift stage.
package lsp_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NUM_OUT = 16;
  localparam int ADDR_W  = 8;
  localparam int DATA_W  = 32;
  localparam int CNT_W   = 8;
  localparam int AGE_W   = 16;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 4;
  localparam int STAGGER_NS    = 20;
  // A longest gap, so round down, never below one cycle
  localparam int STAG_CYC      = (STAGGER_NS / CLK_PERIOD_NS < 1) ? 1
                                 : STAGGER_NS / CLK_PERIOD_NS;
  // Base propagation before the first output: lets the latch settle first
  localparam int SWEEP_LEAD    = 1;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_CTRL     = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_STATUS   = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_INT_STAT = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_INT_MASK = 8'h0C;
  localparam logic [ADDR_W-1:0] ADDR_LATCH    = 8'h10;

  // Field positions
  localparam int CTRL_TEST_BIT = 0;
  localparam int STAT_LOCK_BIT = 0;
  localparam int STAT_HOT_BIT  = 1;
  localparam int STAT_BUSY_BIT = 2;
  localparam int STAT_TEST_BIT = 3;
  localparam int INT_LOCK_BIT  = 0;
  localparam int INT_HOT_BIT   = 1;
  localparam int INT_OPEN_BIT  = 2;
  localparam int INT_W         = 3;

  // Reset values
  localparam logic             TEST_MODE_RST = 1'b0;
  localparam logic [INT_W-1:0] INT_MASK_RST  = 3'h0;
  localparam logic [INT_W-1:0] INT_STAT_RST  = 3'h0;

  // Register selected by an APB address
  typedef enum {
    REG_CTRL,
    REG_STATUS,
    REG_INT_STAT,
    REG_INT_MASK,
    REG_LATCH,
    REG_NONE
  } lsp_reg_t;

endpackage

/* File: design/lsp_top.sv */
// Sink output control: shift stages, latches, staggered output sweep,
// lockout and overtemperature protection, APB registers and interrupt.
// Assumes all pins are synchronous to REF_CLK except the two monitor levels.
//
// Design decisions made here: the placing of the registers and the APB register port.
`timescale 1ns/1ns
module lsp_top #(
  parameter int NUM_OUT = lsp_pkg::NUM_OUT
) (
  // Clock and reset
  input  wire logic                       REF_CLK,
  input  wire logic                       RESET,
  // Host serial pins
  input  wire logic                       SHIFT_CLK,
  input  wire logic                       SERIAL_IN,
  input  wire logic                       LATCH_LOAD,
  input  wire logic                       OUT_GATE,
  output logic                            SERIAL_OUT,
  // Analog monitors and open-LED comparators
  input  wire logic                       SUPPLY_LOW_LOCKOUT,
  input  wire logic                       OVERTEMP_SHUTDOWN,
  input  wire logic [NUM_OUT-1:0]         OPEN_FAULT,
  // Sink drivers, bit 0 is sink_out_first
  output logic      [NUM_OUT-1:0]         SINK_OUT,
  // APB slave
  input  wire logic                       PSEL,
  input  wire logic                       PENABLE,
  input  wire logic                       PWRITE,
  input  wire logic [lsp_pkg::ADDR_W-1:0] PADDR,
  input  wire logic [lsp_pkg::DATA_W-1:0] PWDATA,
  output logic      [lsp_pkg::DATA_W-1:0] PRDATA,
  output logic                            PREADY,
  output logic                            PSLVERR,
  // Interrupt
  output logic                            IRQ
);
  import lsp_pkg::*;

  localparam int IDX_W = (NUM_OUT > 1) ? $clog2(NUM_OUT) : 1;
  localparam logic [IDX_W-1:0] LAST_IDX  = IDX_W'(NUM_OUT - 1);
  localparam logic [CNT_W-1:0] GAP_RLD   = CNT_W'(STAG_CYC - 1);
  localparam logic [CNT_W-1:0] LEAD_RLD  = CNT_W'(SWEEP_LEAD);
  localparam logic [AGE_W-1:0] LAST_AGE  = AGE_W'(SWEEP_LEAD + (NUM_OUT - 1) * STAG_CYC);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic               lock_m_q, lock_s_q, hot_m_q, hot_s_q;
  logic               lock_prev_q, hot_prev_q, prot_prev_q;
  logic               clk_prev_q, ll_prev_q, gate_prev_q;
  logic [NUM_OUT-1:0] shift_q, latch_q, sink_q;
  logic               test_mode_q;
  logic               sw_act_q;
  logic [IDX_W-1:0]   sw_idx_q;
  logic [CNT_W-1:0]   sw_cnt_q;
  logic [AGE_W-1:0]   sw_age_q;
  logic [INT_W-1:0]   int_stat_q, int_stat_d, int_mask_q, int_evt;
  logic               irq_q, pready_q, pslverr_q;
  logic [DATA_W-1:0]  prdata_q, rd_word;
  logic               clk_rise, prot, forced_off, capture, step_fire, trig;
  logic               apb_wr, apb_rd_setup;
  lsp_reg_t           rd_sel;

  // Address decode, shared by the read and write paths
  function automatic lsp_reg_t decode(input logic [ADDR_W-1:0] addr);
    unique case (addr)
      ADDR_CTRL:     decode = REG_CTRL;
      ADDR_STATUS:   decode = REG_STATUS;
      ADDR_INT_STAT: decode = REG_INT_STAT;
      ADDR_INT_MASK: decode = REG_INT_MASK;
      ADDR_LATCH:    decode = REG_LATCH;
      default:       decode = REG_NONE;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Monitor synchronisers and pin edge history
  // ----------------------------------------------------------------
  // Analog levels are asynchronous; two flops guard against metastability
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      lock_m_q <= 1'b0;
      lock_s_q <= 1'b0;
      hot_m_q  <= 1'b0;
      hot_s_q  <= 1'b0;
    end else begin
      lock_m_q <= SUPPLY_LOW_LOCKOUT;
      lock_s_q <= lock_m_q;
      hot_m_q  <= OVERTEMP_SHUTDOWN;
      hot_s_q  <= hot_m_q;
    end
  end

  // Previous values for edge detection
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      lock_prev_q <= 1'b0;
      hot_prev_q  <= 1'b0;
      prot_prev_q <= 1'b0;
      clk_prev_q  <= 1'b0;
      ll_prev_q   <= 1'b0;
      gate_prev_q <= 1'b1;
    end else begin
      lock_prev_q <= lock_s_q;
      hot_prev_q  <= hot_s_q;
      prot_prev_q <= prot;
      clk_prev_q  <= SHIFT_CLK;
      ll_prev_q   <= LATCH_LOAD;
      gate_prev_q <= OUT_GATE;
    end
  end

  assign clk_rise   = SHIFT_CLK & ~clk_prev_q;
  assign prot       = lock_s_q | hot_s_q;
  assign forced_off = prot | OUT_GATE;
  assign capture    = test_mode_q & clk_rise & ~OUT_GATE;
  assign step_fire  = sw_act_q & (sw_cnt_q == '0);
  // Sweep starts: gate active, load rising, clock with load held, protection released
  assign trig = ~forced_off & ((gate_prev_q & ~OUT_GATE)
                             | (LATCH_LOAD & ~ll_prev_q)
                             | (LATCH_LOAD & clk_rise)
                             | prot_prev_q);

  // ----------------------------------------------------------------
  // Shift stages and latches
  // ----------------------------------------------------------------
  // Lockout holds everything at zero, so the release finds them cleared
  always_ff @(posedge REF_CLK) begin
    if (RESET || lock_s_q) begin
      shift_q <= '0;
    end else if (hot_s_q && test_mode_q) begin
      shift_q <= '0;
    end else if (capture) begin
      shift_q <= latch_q & ~OPEN_FAULT;
    end else if (clk_rise) begin
      shift_q <= {shift_q[NUM_OUT-2:0], SERIAL_IN};
    end
  end

  // Latches run on through overtemperature; the gate never touches them
  always_ff @(posedge REF_CLK) begin
    if (RESET || lock_s_q) begin
      latch_q <= '0;
    end else if (LATCH_LOAD) begin
      latch_q <= shift_q;
    end
  end

  assign SERIAL_OUT = shift_q[NUM_OUT-1];

  // Test mode bit; software sets it, lockout drops it
  always_ff @(posedge REF_CLK) begin
    if (RESET || lock_s_q) begin
      test_mode_q <= TEST_MODE_RST;
    end else if (apb_wr && decode(PADDR) == REG_CTRL) begin
      test_mode_q <= PWDATA[CTRL_TEST_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Staggered output sweep
  // ----------------------------------------------------------------
  // One output per step, STAG_CYC cycles apart; a new start restarts at bit 0
  always_ff @(posedge REF_CLK) begin
    if (RESET || forced_off) begin
      sw_act_q <= 1'b0;
      sw_idx_q <= '0;
      sw_cnt_q <= '0;
    end else if (trig) begin
      sw_act_q <= 1'b1;
      sw_idx_q <= '0;
      sw_cnt_q <= LEAD_RLD;
    end else if (step_fire) begin
      sw_act_q <= (sw_idx_q != LAST_IDX);
      sw_idx_q <= (sw_idx_q == LAST_IDX) ? '0 : sw_idx_q + 1'b1;
      sw_cnt_q <= GAP_RLD;
    end else if (sw_act_q) begin
      sw_cnt_q <= sw_cnt_q - 1'b1;
    end
  end

  // Cycles since the sweep began, for the last-output lag assertion
  always_ff @(posedge REF_CLK) begin
    if (RESET || trig) begin
      sw_age_q <= '0;
    end else if (sw_act_q && sw_age_q != '1) begin
      sw_age_q <= sw_age_q + 1'b1;
    end
  end

  // Gate or protection turns all outputs off at once; latch-driven changes, on or off, stagger
  always_ff @(posedge REF_CLK) begin
    if (RESET || forced_off) begin
      sink_q <= '0;
    end else if (step_fire) begin
      sink_q[sw_idx_q] <= latch_q[sw_idx_q];
    end
  end

  assign SINK_OUT = sink_q;

  // ----------------------------------------------------------------
  // Interrupt status and mask
  // ----------------------------------------------------------------
  assign int_evt[INT_LOCK_BIT] = lock_s_q & ~lock_prev_q;
  assign int_evt[INT_HOT_BIT]  = hot_s_q & ~hot_prev_q;
  assign int_evt[INT_OPEN_BIT] = capture & |(latch_q & OPEN_FAULT);

  // A new event beats a write-one-to-clear in the same cycle
  always_comb begin
    int_stat_d = int_stat_q;
    if (apb_wr && decode(PADDR) == REG_INT_STAT) begin
      int_stat_d = int_stat_d & ~PWDATA[INT_W-1:0];
    end
    int_stat_d = int_stat_d | int_evt;
  end

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      int_stat_q <= INT_STAT_RST;
      int_mask_q <= INT_MASK_RST;
      irq_q      <= 1'b0;
    end else begin
      int_stat_q <= int_stat_d;
      if (apb_wr && decode(PADDR) == REG_INT_MASK) begin
        int_mask_q <= PWDATA[INT_W-1:0];
      end
      irq_q <= |(int_stat_q & int_mask_q);
    end
  end

  assign IRQ = irq_q;

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  // One wait state keeps PRDATA and PREADY straight from flops
  assign apb_rd_setup = PSEL & PENABLE & ~pready_q;
  assign apb_wr       = PSEL & PENABLE & PWRITE & pready_q;
  assign rd_sel       = decode(PADDR);

  always_comb begin
    rd_word = '0;
    unique case (rd_sel)
      REG_CTRL:     rd_word[CTRL_TEST_BIT] = test_mode_q;
      REG_STATUS: begin
        rd_word[STAT_LOCK_BIT] = lock_s_q;
        rd_word[STAT_HOT_BIT]  = hot_s_q;
        rd_word[STAT_BUSY_BIT] = sw_act_q;
        rd_word[STAT_TEST_BIT] = test_mode_q;
      end
      REG_INT_STAT: rd_word[INT_W-1:0]   = int_stat_q;
      REG_INT_MASK: rd_word[INT_W-1:0]   = int_mask_q;
      REG_LATCH:    rd_word[NUM_OUT-1:0] = latch_q;
      REG_NONE:     rd_word = '0;
    endcase
  end

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= '0;
    end else begin
      pready_q  <= apb_rd_setup;
      pslverr_q <= apb_rd_setup & (rd_sel == REG_NONE);
      prdata_q  <= (apb_rd_setup && !PWRITE) ? rd_word : '0;
    end
  end

  assign PREADY  = pready_q;
  assign PSLVERR = pslverr_q;
  assign PRDATA  = prdata_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RESET);

  a_lock_forces_off: assert property (
    lock_s_q |=> (SINK_OUT == '0))
    else $error("outputs on during supply-low lockout");

  a_lock_clears_data: assert property (
    $fell(lock_s_q) |-> (shift_q == '0) && (latch_q == '0))
    else $error("shift or latch not cleared at lockout release");

  a_lock_normal_mode: assert property (
    lock_s_q ##1 !lock_s_q |-> !test_mode_q)
    else $error("test mode survived lockout");

  a_stagger_step_gap: assert property (
    step_fire && !trig && !forced_off && sw_idx_q != LAST_IDX |=>
      (sw_cnt_q == GAP_RLD) && (sw_idx_q == $past(sw_idx_q) + 1'b1))
    else $error("stagger step spacing or order wrong");

  a_sweep_start: assert property (
    trig |=> sw_act_q && (sw_idx_q == '0) ##1 (sw_cnt_q == '0) || forced_off || $past(trig))
    else $error("sweep did not start on trigger");

  a_last_output_lag: assert property (
    step_fire && sw_idx_q == LAST_IDX && !trig |-> sw_age_q == LAST_AGE)
    else $error("last output lag wrong");

  a_hot_forces_off: assert property (
    hot_s_q |=> (SINK_OUT == '0))
    else $error("outputs on during overtemperature");

  a_hot_test_zero: assert property (
    hot_s_q && test_mode_q |=> (shift_q == '0))
    else $error("shift not zeroed by overtemperature in test mode");

  a_gate_latch_kept: assert property (
    $changed(OUT_GATE) && !LATCH_LOAD && !lock_s_q |=> $stable(latch_q))
    else $error("gate disturbed latch contents");

  a_latch_follows: assert property (
    LATCH_LOAD && !lock_s_q |=> (latch_q == $past(shift_q)))
    else $error("latch not transparent with load high");

  a_open_fault_zero: assert property (
    capture && !hot_s_q && !lock_s_q |=>
      ((shift_q & $past(OPEN_FAULT)) == '0))
    else $error("faulted output did not read zero");

  a_lock_sync_delay: assert property (
    !$past(RESET) && !$past(RESET, 2) |-> lock_s_q == $past(SUPPLY_LOW_LOCKOUT, 2))
    else $error("lockout synchroniser depth wrong");

endmodule // lsp_top

/* File: dv/lsp_host.sv */
// Host pin model: drives shift clock, serial data, latch load and output gate.
// Assumes the block samples these pins on rising edges of the same clock.
`timescale 1ns/1ns
module lsp_host (
  // Clock
  input  wire logic        clk,
  // Pins towards the block
  output logic             shift_clk,
  output logic             serial_din,
  output logic             latch_load,
  output logic             out_gate,
  // Serial data back from the block
  input  wire logic        serial_dout
);
  // Idle with sinks gated off, so nothing lights before data is loaded
  initial begin
    shift_clk  = 1'b0;
    serial_din = 1'b0;
    latch_load = 1'b0;
    out_gate   = 1'b1;
  end

  // Pin moves, each just after a rising edge; set_clk moves data and clock together
  task automatic set_clk(input logic v, input logic d);
    @(posedge clk);
    serial_din <= d;
    shift_clk  <= v;
  endtask
  task automatic set_gate(input logic v);
    @(posedge clk);
    out_gate <= v;
  endtask
  task automatic set_load(input logic v);
    @(posedge clk);
    latch_load <= v;
  endtask

  // Fast word shifts happen only with load low; the caller spaces edges taken
  // with load high by a whole sweep, so staggered outputs never get cut off
  task automatic shift_word(input logic [15:0] d, output logic [15:0] seen);
    for (int i = 15; i >= 0; i--) begin
      set_clk(1'b0, d[i]);
      @(posedge clk);
      #1 seen[i] = serial_dout;
      set_clk(1'b1, d[i]);
      @(posedge clk);
    end
    set_clk(1'b0, 1'b0);
  endtask
endmodule // lsp_host

/* File: dv/lsp_top_test.sv */
// Self-checking bench for the sink output block: APB tasks and a host pin model.
// Assumes the bench drives the monitor levels, open-LED comparators and APB.
`timescale 1ns/1ns
module lsp_top_test;
  import lsp_pkg::*;
  `define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin errors++; \
    $display("wrong value %s expected %0h seen %0h", nm, ex, got); end end
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic                REF_CLK, RESET, SHIFT_CLK, SERIAL_IN, LATCH_LOAD, OUT_GATE;
  logic                SERIAL_OUT, SUPPLY_LOW_LOCKOUT, OVERTEMP_SHUTDOWN;
  logic [NUM_OUT-1:0]  OPEN_FAULT, SINK_OUT;
  logic                PSEL, PENABLE, PWRITE, PREADY, PSLVERR, IRQ;
  logic [ADDR_W-1:0]   PADDR;
  logic [DATA_W-1:0]   PWDATA, PRDATA, rd;
  logic                er;
  logic [15:0]         seen;
  int                  errors, total_checks;
  logic [ADDR_W-1:0]   addrs[5] = '{ADDR_CTRL, ADDR_STATUS, ADDR_INT_STAT, ADDR_INT_MASK,
                                    ADDR_LATCH};

  lsp_top #(.NUM_OUT(NUM_OUT)) dut (.REF_CLK(REF_CLK), .RESET(RESET), .SHIFT_CLK(SHIFT_CLK),
    .SERIAL_IN(SERIAL_IN), .LATCH_LOAD(LATCH_LOAD), .OUT_GATE(OUT_GATE),
    .SERIAL_OUT(SERIAL_OUT), .SUPPLY_LOW_LOCKOUT(SUPPLY_LOW_LOCKOUT),
    .OVERTEMP_SHUTDOWN(OVERTEMP_SHUTDOWN), .OPEN_FAULT(OPEN_FAULT), .SINK_OUT(SINK_OUT),
    .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .IRQ(IRQ));
  lsp_host host (.clk(REF_CLK), .shift_clk(SHIFT_CLK), .serial_din(SERIAL_IN),
    .latch_load(LATCH_LOAD), .out_gate(OUT_GATE), .serial_dout(SERIAL_OUT));

  // 250 MHz clock
  always #2 REF_CLK = ~REF_CLK;

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  // APB transfer; answer taken at the edge where PREADY is sampled high
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                     output logic [DATA_W-1:0] r, output logic e);
    @(posedge REF_CLK);
    PSEL    <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE  <= w;
    PADDR   <= a;
    PWDATA  <= d;
    @(posedge REF_CLK);
    PENABLE <= 1'b1;
    // Values read here are those sampled at the edge; only the watchdog ends a hang
    do begin
      @(posedge REF_CLK);
    end while (PREADY !== 1'b1);
    r = PRDATA;
    e = PSLVERR;
    PSEL    <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    logic [DATA_W-1:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd_chk(input string nm, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] ex);
    logic [DATA_W-1:0] r;
    logic e;
    apb(1'b0, a, '0, r, e);
    `CHK(nm, ex, r)
  endtask
  // Watch one sweep: bit k must take its new value 5 cycles after bit k-1
  task automatic sweep(input logic [15:0] o, input logic [15:0] n);
    int t0;
    logic [15:0] m;
    t0 = -1;
    for (int c = 0; c < 100; c++) begin
      @(posedge REF_CLK);
      #1 if (t0 < 0 && SINK_OUT !== o) t0 = c;
      if (t0 >= 0) begin
        for (int k = 0; k < 16; k++) m[k] = (c - t0 >= 5 * k);
        `CHK("sweep", (n & m) | (o & ~m), SINK_OUT)
      end
    end
    `CHK("sweep start", 1'b1, t0 >= 0 && t0 < 8)
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge REF_CLK);
    #1;
  endtask
  task automatic give_verdict;
    $display("checks %0d, mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Watchdog, well past the fewer than two thousand cycles the tests need
  initial begin
    repeat (20000) @(posedge REF_CLK);
    errors++;
    give_verdict;
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    REF_CLK = 0; RESET = 1; PSEL = 0; PENABLE = 0; PWRITE = 0; PADDR = '0; PWDATA = '0;
    SUPPLY_LOW_LOCKOUT = 0; OVERTEMP_SHUTDOWN = 0; OPEN_FAULT = '0;
    errors = 0; total_checks = 0;
    repeat (20) @(posedge REF_CLK);
    RESET <= 1'b0;
    wait_cyc(1);
    `CHK("sink reset", 16'h0, SINK_OUT)
    foreach (addrs[i]) rd_chk("reg reset", addrs[i], 32'h0);
    apb(1'b0, 8'h14, '0, rd, er);
    `CHK("unmapped err", 1'b1, er)
    // Gate falls, load rises, clock rises with load held
    host.shift_word(16'hFFFF, seen);
    host.set_load(1'b1);
    host.set_load(1'b0);
    host.set_gate(1'b0);
    sweep(16'h0, 16'hFFFF);
    host.shift_word(16'hAAAA, seen);
    host.set_load(1'b1);
    sweep(16'hFFFF, 16'hAAAA);
    host.set_clk(1'b1, 1'b1);
    sweep(16'hAAAA, 16'h5555);
    host.set_clk(1'b0, 1'b0);
    host.set_load(1'b0);
    host.set_gate(1'b1);
    wait_cyc(2);
    `CHK("gate off", 16'h0, SINK_OUT)
    host.shift_word(16'h1235, seen);
    rd_chk("latch held", ADDR_LATCH, 32'h5555);
    // Overtemperature in normal mode keeps data moving
    host.set_gate(1'b0);
    sweep(16'h0, 16'h5555);
    @(posedge REF_CLK);
    OVERTEMP_SHUTDOWN <= 1'b1;
    wait_cyc(4);
    `CHK("hot off", 16'h0, SINK_OUT)
    host.set_load(1'b1);
    host.set_load(1'b0);
    rd_chk("latch hot", ADDR_LATCH, 32'h1235);
    rd_chk("status hot", ADDR_STATUS, 32'h2);
    rd_chk("int hot", ADDR_INT_STAT, 32'h2);
    `CHK("irq masked", 1'b0, IRQ)
    wr(ADDR_INT_MASK, 32'h2);
    wait_cyc(3);
    `CHK("irq on", 1'b1, IRQ)
    wr(ADDR_INT_STAT, 32'h2);
    wait_cyc(3);
    `CHK("irq cleared", 1'b0, IRQ)
    @(posedge REF_CLK);
    OVERTEMP_SHUTDOWN <= 1'b0;
    sweep(16'h0, 16'h1235);
    // Test mode: open capture, then overtemperature zeroes the shift stages
    wr(ADDR_CTRL, 32'h1);
    rd_chk("test mode", ADDR_STATUS, 32'h8);
    host.set_gate(1'b1);
    host.shift_word(16'hFFFF, seen);
    host.set_load(1'b1);
    host.set_load(1'b0);
    host.set_gate(1'b0);
    @(posedge REF_CLK);
    OPEN_FAULT <= 16'h80F1;
    wait_cyc(90);
    host.set_clk(1'b1, 1'b0);
    host.set_clk(1'b0, 1'b0);
    host.set_gate(1'b1);
    wait_cyc(4);
    host.shift_word(16'hFFFF, seen);
    `CHK("open capture", 16'h7F0E, seen)
    rd_chk("int open", ADDR_INT_STAT, 32'h4);
    @(posedge REF_CLK);
    OVERTEMP_SHUTDOWN <= 1'b1;
    wait_cyc(6);
    @(posedge REF_CLK);
    OVERTEMP_SHUTDOWN <= 1'b0;
    host.shift_word(16'h0, seen);
    `CHK("hot zeroes", 16'h0, seen)
    // Lockout forces sinks off and clears shift stages, latches and test mode on recovery
    host.shift_word(16'hFFFF, seen);
    host.set_gate(1'b0);
    wait_cyc(90);
    @(posedge REF_CLK);
    SUPPLY_LOW_LOCKOUT <= 1'b1;
    wait_cyc(4);
    `CHK("lockout off", 16'h0, SINK_OUT)
    @(posedge REF_CLK);
    SUPPLY_LOW_LOCKOUT <= 1'b0;
    wait_cyc(100);
    `CHK("sink cleared", 16'h0, SINK_OUT)
    rd_chk("latch cleared", ADDR_LATCH, 32'h0);
    rd_chk("normal mode", ADDR_CTRL, 32'h0);
    host.shift_word(16'h0, seen);
    `CHK("shift cleared", 16'h0, seen)
    rd_chk("int lock", ADDR_INT_STAT, 32'h7);
    // Mid-run reset with data loaded and test mode set: all must come back cleared
    wr(ADDR_CTRL, 32'h1);
    host.set_gate(1'b1);
    host.shift_word(16'hFFFF, seen);
    host.set_load(1'b1);
    host.set_load(1'b0);
    @(posedge REF_CLK);
    RESET <= 1'b1;
    repeat (3) @(posedge REF_CLK);
    RESET <= 1'b0;
    wait_cyc(2);
    rd_chk("reset latch", ADDR_LATCH, 32'h0);
    rd_chk("reset mode", ADDR_CTRL, 32'h0);
    host.shift_word(16'h0, seen);
    `CHK("reset shift", 16'h0, seen)
    give_verdict;
  end
endmodule // lsp_top_test
